// ### hw/dual_timer_params.svh
// register offsets, field positions, mode codes and lag depths of the dual timer
`ifndef DUAL_TIMER_PARAMS_SVH
`define DUAL_TIMER_PARAMS_SVH

// ==================================================================
// register byte offsets
`define FIRST_TIMER_CONTROL_OFS          8'h00
`define FIRST_TIMER_IO_CONTROL_OFS       8'h04
`define FIRST_TIMER_MODE_SELECT_OFS      8'h08
`define FIRST_TIMER_PRESCALER_OFS        8'h0c
`define FIRST_TIMER_COUNTER_OFS          8'h10
`define SECOND_TIMER_CONTROL_OFS         8'h20
`define SECOND_TIMER_ONESHOT_CONTROL_OFS 8'h24
`define SECOND_TIMER_IO_CONTROL_OFS      8'h28
`define SECOND_TIMER_MODE_SELECT_OFS     8'h2c
`define SECOND_TIMER_PRESCALER_OFS       8'h30
`define SECOND_TIMER_SECONDARY_RELOAD_OFS 8'h34
`define SECOND_TIMER_PRIMARY_RELOAD_OFS  8'h38

// ==================================================================
// field positions
`define CTL_START_BIT      0
`define CTL_STATUS_BIT     1
`define CTL_FSTOP_BIT      2
`define CTL_EDGE_BIT       5
`define CTL_UNF_BIT        6
`define OS_TRIGGER_BIT     0
`define OS_STOP_BIT        1
`define OS_STATUS_BIT      2
`define IO_POL_BIT         0
`define B_SRC_SEL_BIT      4

// ==================================================================
// mode codes
`define A_MODE_TIMER       3'h0
`define A_MODE_PULSE_OUT   3'h1
`define A_MODE_EVENT       3'h2
`define A_MODE_WIDTH       3'h3
`define A_MODE_PERIOD      3'h4
`define B_MODE_TIMER       2'h0
`define B_MODE_WAVE        2'h1
`define B_MODE_ONESHOT     2'h2
`define B_MODE_WAIT_ONESHOT 2'h3

// ==================================================================
// reset values, lag depths in count-source edges, bus answers
`define BYTE_RST_VAL       8'h00
`define A_LAG_STAGES       1
`define B_LAG_STAGES       2
`define OS_LAG_STAGES      2
`define UNMAPPED_DATA      32'h0000_0000

`endif

// ### hw/dual_timer_pkg.sv
// types shared by the dual prescaled timer modules
package dual_timer_pkg;

    // ==================================================================
    // one-shot sequencing
    typedef enum logic [2:0] {
        OS_IDLE  = 3'b001,
        OS_WAIT  = 3'b010,
        OS_PULSE = 3'b100
    } oneshot_state_t;

    // ==================================================================
    // lag stage state
    typedef struct packed {
        logic [1:0] sh;
    } lag_state_t;

    // ==================================================================
    // timer state
    typedef struct packed {
        logic           pready;
        logic           pslverr;
        logic [31:0]    prdata;
        logic           a_src_q;
        logic           b_src_q;
        logic           a_pin_q;
        logic           a_start;
        logic           a_edge_f;
        logic           a_unf_f;
        logic           a_out;
        logic [7:0]     a_io;
        logic [2:0]     a_mode;
        logic [7:0]     a_pre_rld;
        logic [7:0]     a_pre_cnt;
        logic [7:0]     a_rld;
        logic [7:0]     a_cnt;
        logic           b_start;
        logic           b_unf_f;
        logic           b_out;
        logic           b_src_sel;
        logic           os_req;
        logic [7:0]     b_io;
        logic [1:0]     b_mode;
        logic [7:0]     b_pre_rld;
        logic [7:0]     b_pre_cnt;
        logic [7:0]     b_sec;
        logic [7:0]     b_pri;
        logic [7:0]     b_cnt;
        oneshot_state_t os_state;
    } timer_state_t;

endpackage

// ### hw/count_source_lag.sv
// delays a start or one-shot request by whole count-source edges
`timescale 1ns/100ps
`default_nettype none

module count_source_lag #(
    parameter int STAGES = 1
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_b,
    // count-source edge and request
    input  wire logic tick,
    input  wire logic clear,
    input  wire logic req,
    // lagged request
    output logic      lag
);

    dual_timer_pkg::lag_state_t st_r;
    dual_timer_pkg::lag_state_t st_nxt;

    // ==================================================================
    // shift on each count-source edge, clear at once
    always_comb begin
        st_nxt = st_r;
        if (clear) begin
            st_nxt.sh = 2'h0;
        end else if (tick) begin
            st_nxt.sh = {st_r.sh[0], req};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lag = (STAGES == 1) ? st_r.sh[0] : st_r.sh[1];

endmodule

`default_nettype wire

// ### hw/dual_prescaled_timer.sv
// two prescaled 8-bit timers with measurement, pulse, waveform and one-shot modes
`timescale 1ns/100ps
`default_nettype none
`include "dual_timer_params.svh"

module dual_prescaled_timer (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // count sources and pins
    input  wire logic        a_count_src,
    input  wire logic        b_count_src,
    input  wire logic        a_meas_pin,
    output logic             a_pulse_out,
    output logic             b_wave_out
);

    dual_timer_pkg::timer_state_t st_r;
    dual_timer_pkg::timer_state_t st_nxt;

    logic a_lag;
    logic b_lag;
    logic os_lag;
    logic a_src_edge;
    logic b_src_edge;
    logic pin_act;
    logic pin_was_act;
    logic act_edge;
    logic inact_edge;
    logic a_meas;
    logic a_cs_tick;
    logic a_tick;
    logic a_pre_unf;
    logic a_unf;
    logic a_meas_edge;
    logic b_oneshot;
    logic b_cs_tick;
    logic b_tick;
    logic b_pre_unf;
    logic b_unf;
    logic setup;
    logic wr;
    logic fstop;

    // ==================================================================
    // helpers
    function automatic logic [7:0] down8(input logic [7:0] cnt, input logic [7:0] rld);
        down8 = (cnt == 8'h00) ? rld : cnt - 8'h01;
    endfunction

    function automatic logic [7:0] lo8(input logic [31:0] d);
        lo8 = d[7:0];
    endfunction

    // ==================================================================
    // bus phases
    assign setup = psel & ~penable;
    assign wr    = psel & penable & pwrite & st_r.pready;
    assign fstop = wr & (paddr == `SECOND_TIMER_CONTROL_OFS) & pwdata[`CTL_FSTOP_BIT];

    // ==================================================================
    // first timer count source
    assign a_src_edge  = a_count_src & ~st_r.a_src_q;
    assign pin_act     = a_meas_pin ^ st_r.a_io[`IO_POL_BIT];
    assign pin_was_act = st_r.a_pin_q ^ st_r.a_io[`IO_POL_BIT];
    assign act_edge    = pin_act & ~pin_was_act;
    assign inact_edge  = ~pin_act & pin_was_act;
    assign a_meas      = (st_r.a_mode == `A_MODE_WIDTH) | (st_r.a_mode == `A_MODE_PERIOD);
    assign a_cs_tick   = (st_r.a_mode == `A_MODE_EVENT) ? act_edge : a_src_edge;
    // counting only once the status flag is already up
    assign a_tick      = a_lag & a_cs_tick
                       & ((st_r.a_mode != `A_MODE_WIDTH) | pin_act);
    assign a_pre_unf   = a_tick & (st_r.a_pre_cnt == 8'h00);
    assign a_unf       = a_pre_unf & (st_r.a_cnt == 8'h00);
    assign a_meas_edge = a_lag & (((st_r.a_mode == `A_MODE_PERIOD) & act_edge)
                       | ((st_r.a_mode == `A_MODE_WIDTH) & inact_edge));

    count_source_lag #(
        .STAGES (`A_LAG_STAGES)
    ) u_a_lag (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .tick    (a_cs_tick),
        .clear   (1'b0),
        .req     (st_r.a_start),
        .lag     (a_lag)
    );

    // ==================================================================
    // second timer count source
    assign b_src_edge = b_count_src & ~st_r.b_src_q;
    assign b_oneshot  = st_r.b_mode[1];
    assign b_cs_tick  = st_r.b_src_sel ? a_unf : b_src_edge;
    // forced stop gates the tick in the very cycle of the write
    assign b_tick     = b_lag & b_cs_tick & ~fstop
                      & (~b_oneshot | (st_r.os_state != dual_timer_pkg::OS_IDLE));
    assign b_pre_unf  = b_tick & (st_r.b_pre_cnt == 8'h00);
    assign b_unf      = b_pre_unf & (st_r.b_cnt == 8'h00);

    count_source_lag #(
        .STAGES (`B_LAG_STAGES)
    ) u_b_lag (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .tick    (b_cs_tick),
        .clear   (fstop),
        .req     (st_r.b_start),
        .lag     (b_lag)
    );

    count_source_lag #(
        .STAGES (`OS_LAG_STAGES)
    ) u_os_lag (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .tick    (b_cs_tick),
        .clear   (fstop),
        .req     (st_r.os_req),
        .lag     (os_lag)
    );

    // ==================================================================
    // next state
    always_comb begin
        logic [31:0] rd;
        logic        hit;
        logic        os_halt;
        rd      = '0;
        hit     = 1'b1;
        os_halt = 1'b0;
        st_nxt  = st_r;
        st_nxt.a_src_q = a_count_src;
        st_nxt.b_src_q = b_count_src;
        st_nxt.a_pin_q = a_meas_pin;
        st_nxt.pready  = 1'b0;
        st_nxt.pslverr = 1'b0;

        // first timer counting
        if (a_tick) begin
            st_nxt.a_pre_cnt = down8(st_r.a_pre_cnt, st_r.a_pre_rld);
        end
        if (a_pre_unf) begin
            st_nxt.a_cnt = down8(st_r.a_cnt, st_r.a_rld);
        end
        if (a_meas_edge) begin
            st_nxt.a_cnt     = st_r.a_rld;
            st_nxt.a_pre_cnt = st_r.a_pre_rld;
        end
        if (a_unf && (st_r.a_mode == `A_MODE_PULSE_OUT)) begin
            st_nxt.a_out = ~st_r.a_out;
        end

        // second timer counting
        if (b_tick) begin
            st_nxt.b_pre_cnt = down8(st_r.b_pre_cnt, st_r.b_pre_rld);
        end
        if (b_pre_unf) begin
            st_nxt.b_cnt = down8(st_r.b_cnt, st_r.b_pri);
        end
        if (b_unf && (st_r.b_mode == `B_MODE_WAVE)) begin
            st_nxt.b_cnt = st_r.b_out ? st_r.b_pri : st_r.b_sec;
            st_nxt.b_out = ~st_r.b_out;
        end

        // one-shot sequencing
        case (st_r.os_state)
            dual_timer_pkg::OS_IDLE: begin
                if (b_oneshot && b_lag && os_lag && st_r.os_req) begin
                    st_nxt.b_pre_cnt = st_r.b_pre_rld;
                    if (st_r.b_mode == `B_MODE_WAIT_ONESHOT) begin
                        st_nxt.os_state = dual_timer_pkg::OS_WAIT;
                        st_nxt.b_cnt    = st_r.b_sec;
                    end else begin
                        st_nxt.os_state = dual_timer_pkg::OS_PULSE;
                        st_nxt.b_cnt    = st_r.b_pri;
                        st_nxt.b_out    = 1'b1;
                    end
                end
            end
            dual_timer_pkg::OS_WAIT: begin
                if (b_unf) begin
                    st_nxt.os_state = dual_timer_pkg::OS_PULSE;
                    st_nxt.b_cnt    = st_r.b_pri;
                    st_nxt.b_out    = 1'b1;
                end
            end
            dual_timer_pkg::OS_PULSE: begin
                if (b_unf) begin
                    st_nxt.os_state = dual_timer_pkg::OS_IDLE;
                    st_nxt.b_cnt    = st_r.b_pri;
                    st_nxt.b_out    = 1'b0;
                    st_nxt.os_req   = 1'b0;
                end
            end
            default: begin
                st_nxt.os_state = dual_timer_pkg::OS_IDLE;
            end
        endcase

        // register read decode
        case (paddr)
            `FIRST_TIMER_CONTROL_OFS: begin
                rd[`CTL_START_BIT]  = st_r.a_start;
                rd[`CTL_STATUS_BIT] = a_lag;
                rd[`CTL_EDGE_BIT]   = st_r.a_edge_f;
                rd[`CTL_UNF_BIT]    = st_r.a_unf_f;
            end
            `FIRST_TIMER_IO_CONTROL_OFS:  rd[7:0] = st_r.a_io;
            `FIRST_TIMER_MODE_SELECT_OFS: rd[2:0] = st_r.a_mode;
            `FIRST_TIMER_PRESCALER_OFS:   rd[7:0] = st_r.a_pre_cnt;
            `FIRST_TIMER_COUNTER_OFS:     rd[7:0] = st_r.a_cnt;
            `SECOND_TIMER_CONTROL_OFS: begin
                rd[`CTL_START_BIT]  = st_r.b_start;
                rd[`CTL_STATUS_BIT] = b_lag;
                rd[`CTL_UNF_BIT]    = st_r.b_unf_f;
            end
            `SECOND_TIMER_ONESHOT_CONTROL_OFS: rd[`OS_STATUS_BIT] = os_lag;
            `SECOND_TIMER_IO_CONTROL_OFS:  rd[7:0] = st_r.b_io;
            `SECOND_TIMER_MODE_SELECT_OFS: begin
                rd[1:0]             = st_r.b_mode;
                rd[`B_SRC_SEL_BIT]  = st_r.b_src_sel;
            end
            `SECOND_TIMER_PRESCALER_OFS:        rd[7:0] = st_r.b_pre_cnt;
            `SECOND_TIMER_SECONDARY_RELOAD_OFS: rd[7:0] = st_r.b_sec;
            `SECOND_TIMER_PRIMARY_RELOAD_OFS:   rd[7:0] = st_r.b_cnt;
            default: hit = 1'b0;
        endcase

        // apb answer, one wait-free access phase
        if (setup) begin
            st_nxt.pready  = 1'b1;
            st_nxt.prdata  = hit ? rd : `UNMAPPED_DATA;
            st_nxt.pslverr = ~hit;
        end

        // register writes
        if (wr) begin
            case (paddr)
                `FIRST_TIMER_CONTROL_OFS: begin
                    st_nxt.a_start = pwdata[`CTL_START_BIT];
                    if (a_meas && !pwdata[`CTL_EDGE_BIT]) begin
                        st_nxt.a_edge_f = 1'b0;
                    end
                    if (a_meas && !pwdata[`CTL_UNF_BIT]) begin
                        st_nxt.a_unf_f = 1'b0;
                    end
                end
                `FIRST_TIMER_IO_CONTROL_OFS:  st_nxt.a_io = lo8(pwdata);
                `FIRST_TIMER_MODE_SELECT_OFS: st_nxt.a_mode = pwdata[2:0];
                `FIRST_TIMER_PRESCALER_OFS: begin
                    st_nxt.a_pre_rld = lo8(pwdata);
                    if (!a_lag) begin
                        st_nxt.a_pre_cnt = lo8(pwdata);
                    end
                end
                `FIRST_TIMER_COUNTER_OFS: begin
                    st_nxt.a_rld = lo8(pwdata);
                    if (!a_lag) begin
                        st_nxt.a_cnt = lo8(pwdata);
                    end
                end
                `SECOND_TIMER_CONTROL_OFS: begin
                    st_nxt.b_start = pwdata[`CTL_START_BIT];
                    if (!pwdata[`CTL_UNF_BIT]) begin
                        st_nxt.b_unf_f = 1'b0;
                    end
                    if (b_oneshot && !pwdata[`CTL_START_BIT]) begin
                        os_halt = 1'b1;
                    end
                    if (pwdata[`CTL_FSTOP_BIT]) begin
                        st_nxt.b_start = 1'b0;
                        os_halt        = 1'b1;
                    end
                end
                `SECOND_TIMER_ONESHOT_CONTROL_OFS: begin
                    if (pwdata[`OS_STOP_BIT]) begin
                        os_halt = 1'b1;
                    end else if (pwdata[`OS_TRIGGER_BIT]) begin
                        st_nxt.os_req = 1'b1;
                    end
                end
                `SECOND_TIMER_IO_CONTROL_OFS: st_nxt.b_io = lo8(pwdata);
                `SECOND_TIMER_MODE_SELECT_OFS: begin
                    st_nxt.b_mode    = pwdata[1:0];
                    st_nxt.b_src_sel = pwdata[`B_SRC_SEL_BIT];
                end
                `SECOND_TIMER_PRESCALER_OFS: begin
                    st_nxt.b_pre_rld = lo8(pwdata);
                    if (!b_lag) begin
                        st_nxt.b_pre_cnt = lo8(pwdata);
                    end
                end
                `SECOND_TIMER_SECONDARY_RELOAD_OFS: st_nxt.b_sec = lo8(pwdata);
                `SECOND_TIMER_PRIMARY_RELOAD_OFS: begin
                    st_nxt.b_pri = lo8(pwdata);
                    if (!b_lag) begin
                        st_nxt.b_cnt = lo8(pwdata);
                    end
                end
                default: begin
                    st_nxt.os_req = st_r.os_req;
                end
            endcase
        end

        // one-shot stop: reload from primary, then idle
        if (os_halt) begin
            st_nxt.b_cnt     = st_r.b_pri;
            st_nxt.b_pre_cnt = st_r.b_pre_rld;
            st_nxt.os_state  = dual_timer_pkg::OS_IDLE;
            st_nxt.os_req    = 1'b0;
            st_nxt.b_out     = 1'b0;
        end

        // hardware sets win over software clears
        if (a_meas && a_unf) begin
            st_nxt.a_unf_f = 1'b1;
        end
        if (a_meas_edge) begin
            st_nxt.a_edge_f = 1'b1;
        end
        if (b_unf) begin
            st_nxt.b_unf_f = 1'b1;
        end
    end

    // ==================================================================
    // state register
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r          <= '0;
            st_r.os_state <= dual_timer_pkg::OS_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==================================================================
    // outputs
    assign prdata      = st_r.prdata;
    assign pready      = st_r.pready;
    assign pslverr     = st_r.pslverr;
    assign a_pulse_out = st_r.a_out;
    assign b_wave_out  = st_r.b_out;

endmodule

`default_nettype wire

// ### dv/dual_timer_properties.sv
// port-level concurrent checks for the dual prescaled timer
`timescale 1ns/100ps
`default_nettype none

module dual_timer_checker (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // apb slave side
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // count source and outputs
    input  wire logic        a_count_src,
    input  wire logic        a_pulse_out,
    input  wire logic        b_wave_out
);
    logic wrote_r;
    logic mapped;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // ==================================================================
    // helpers
    assign mapped = paddr[1:0] == 2'h0 && (paddr <= 8'h10 || (paddr >= 8'h20 && paddr <= 8'h38));

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrote_r <= 1'b0;
        end else if (psel && penable && pready && pwrite) begin
            wrote_r <= 1'b1;
        end
    end

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence

    // ==================================================================
    // assertions
    a_ready_after_setup: assert property (setup_s |=> access_s ##0 pready)
        else $error("no pready after setup");
    a_ready_in_access: assert property (pready |-> access_s ##0 ($past(psel) && !$past(penable)))
        else $error("pready outside first access cycle");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_on_hole: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match address map");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_byte_read: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data wider than a byte");
    a_hole_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_idle_after_reset: assert property (!wrote_r |-> !a_pulse_out && !b_wave_out)
        else $error("output active before any write");
    a_pulse_on_tick: assert property ($changed(a_pulse_out) |->
        ($past(a_count_src) && !$past(a_count_src, 2)) || ($past(pready) && $past(pwrite)))
        else $error("pulse output moved without count edge");
endmodule

`default_nettype wire

// ### dv/tb_top.sv
// self-checking bench for the dual prescaled timer
`timescale 1ns/100ps
`default_nettype none
`include "dual_timer_params.svh"

module tb_top;
    logic        sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, re;
    logic        a_count_src, b_count_src, a_meas_pin, a_pulse_out, b_wave_out;
    logic [7:0]  paddr, rq, v;
    logic [31:0] pwdata, prdata;
    int          n_errors, total_checks;

    dual_prescaled_timer dual_prescaled_timer_inst (
        .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .a_count_src(a_count_src), .b_count_src(b_count_src), .a_meas_pin(a_meas_pin),
        .a_pulse_out(a_pulse_out), .b_wave_out(b_wave_out));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ==================================================================
    // tasks
    task automatic tally_and_finish();
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_errors++;
            $display("ERROR %0t ns: bus answer timed out", $time);
            tally_and_finish();
        end
        rq = prdata[7:0];
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        chk(rq, x);
    endtask

    // one rising edge on both count sources per step
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            a_count_src <= 1'b1;
            b_count_src <= 1'b1;
            repeat (2) @(posedge sys_clk);
            a_count_src <= 1'b0;
            b_count_src <= 1'b0;
            repeat (2) @(posedge sys_clk);
        end
    endtask

    // ==================================================================
    // main sequence
    initial begin
        {psel, penable, pwrite, a_count_src, b_count_src, a_meas_pin} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        rst_b = 1'b0;
        n_errors = 0;
        total_checks = 0;
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            rd(8'(i * 4), 8'h00);
            chk({7'h0, re}, {7'h0, ((i > 4 && i < 8) || i == 15)});
        end
        wr(8'h14, 8'hff);
        chk({7'h0, re}, 8'h01);
        // both timers: load, start lag, count, stop lag
        wr(`FIRST_TIMER_MODE_SELECT_OFS, {5'h0, `A_MODE_PULSE_OUT});
        wr(`FIRST_TIMER_PRESCALER_OFS, 8'h00);
        wr(`FIRST_TIMER_COUNTER_OFS, 8'h02);
        wr(`SECOND_TIMER_PRESCALER_OFS, 8'h00);
        wr(`SECOND_TIMER_PRIMARY_RELOAD_OFS, 8'h02);
        tick(3);
        rd(`FIRST_TIMER_COUNTER_OFS, 8'h02);
        rd(`SECOND_TIMER_PRIMARY_RELOAD_OFS, 8'h02);
        wr(`FIRST_TIMER_CONTROL_OFS, 8'h01);
        wr(`SECOND_TIMER_CONTROL_OFS, 8'h01);
        rd(`SECOND_TIMER_CONTROL_OFS, 8'h01);
        tick(1);
        rd(`FIRST_TIMER_CONTROL_OFS, 8'h03);
        rd(`FIRST_TIMER_COUNTER_OFS, 8'h02);
        tick(1);
        rd(`SECOND_TIMER_CONTROL_OFS, 8'h03);
        rd(`FIRST_TIMER_COUNTER_OFS, 8'h01);
        rd(`SECOND_TIMER_PRIMARY_RELOAD_OFS, 8'h02);
        tick(2);
        chk({7'h0, a_pulse_out}, 8'h01);
        rd(`FIRST_TIMER_COUNTER_OFS, 8'h02);
        rd(`SECOND_TIMER_PRIMARY_RELOAD_OFS, 8'h00);
        wr(`FIRST_TIMER_CONTROL_OFS, 8'h00);
        wr(`SECOND_TIMER_CONTROL_OFS, 8'h00);
        rd(`SECOND_TIMER_CONTROL_OFS, 8'h02);
        tick(1);
        rd(`FIRST_TIMER_CONTROL_OFS, 8'h00);
        apb(1'b0, `FIRST_TIMER_COUNTER_OFS, 8'h00);
        v = rq;
        tick(1);
        rd(`SECOND_TIMER_CONTROL_OFS, 8'h40);
        tick(2);
        rd(`FIRST_TIMER_COUNTER_OFS, v);
        // measurement flags: write 1 keeps, write 0 clears
        wr(`FIRST_TIMER_MODE_SELECT_OFS, {5'h0, `A_MODE_PERIOD});
        wr(`FIRST_TIMER_COUNTER_OFS, 8'h01);
        wr(`FIRST_TIMER_CONTROL_OFS, 8'h00);
        wr(`FIRST_TIMER_CONTROL_OFS, 8'h01);
        tick(4);
        a_meas_pin <= 1'b1;
        apb(1'b0, `FIRST_TIMER_CONTROL_OFS, 8'h00);
        chk(rq & 8'h63, 8'h63);
        wr(`FIRST_TIMER_CONTROL_OFS, 8'h61);
        apb(1'b0, `FIRST_TIMER_CONTROL_OFS, 8'h00);
        chk(rq & 8'h60, 8'h60);
        wr(`FIRST_TIMER_CONTROL_OFS, 8'h01);
        apb(1'b0, `FIRST_TIMER_CONTROL_OFS, 8'h00);
        chk(rq & 8'h60, 8'h00);
        wr(`FIRST_TIMER_CONTROL_OFS, 8'h00);
        tick(1);
        // second timer one-shot: trigger, stop reload, forced stop
        wr(`SECOND_TIMER_MODE_SELECT_OFS, {6'h0, `B_MODE_ONESHOT});
        wr(`SECOND_TIMER_PRIMARY_RELOAD_OFS, 8'h03);
        wr(`SECOND_TIMER_CONTROL_OFS, 8'h01);
        tick(2);
        wr(`SECOND_TIMER_ONESHOT_CONTROL_OFS, 8'h01);
        apb(1'b0, `SECOND_TIMER_ONESHOT_CONTROL_OFS, 8'h00);
        chk(rq & 8'h04, 8'h00);
        tick(2);
        apb(1'b0, `SECOND_TIMER_ONESHOT_CONTROL_OFS, 8'h00);
        chk(rq & 8'h04, 8'h04);
        chk({7'h0, b_wave_out}, 8'h01);
        wr(`SECOND_TIMER_ONESHOT_CONTROL_OFS, 8'h02);
        tick(2);
        apb(1'b0, `SECOND_TIMER_ONESHOT_CONTROL_OFS, 8'h00);
        chk(rq & 8'h04, 8'h00);
        rd(`SECOND_TIMER_PRIMARY_RELOAD_OFS, 8'h03);
        chk({7'h0, b_wave_out}, 8'h00);
        tick(1);
        rd(`SECOND_TIMER_PRIMARY_RELOAD_OFS, 8'h03);
        wr(`SECOND_TIMER_ONESHOT_CONTROL_OFS, 8'h01);
        tick(2);
        wr(`SECOND_TIMER_CONTROL_OFS, 8'h05);
        rd(`SECOND_TIMER_CONTROL_OFS, 8'h00);
        apb(1'b0, `SECOND_TIMER_ONESHOT_CONTROL_OFS, 8'h00);
        chk(rq & 8'h04, 8'h00);
        // chained: second timer counts first timer underflows
        wr(`FIRST_TIMER_MODE_SELECT_OFS, {5'h0, `A_MODE_TIMER});
        wr(`FIRST_TIMER_COUNTER_OFS, 8'h00);
        wr(`SECOND_TIMER_MODE_SELECT_OFS, 8'h10);
        wr(`SECOND_TIMER_PRIMARY_RELOAD_OFS, 8'h05);
        wr(`FIRST_TIMER_CONTROL_OFS, 8'h01);
        wr(`SECOND_TIMER_CONTROL_OFS, 8'h01);
        tick(5);
        rd(`SECOND_TIMER_PRIMARY_RELOAD_OFS, 8'h03);
        tally_and_finish();
    end
endmodule

bind dual_prescaled_timer dual_timer_checker dual_timer_checker_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .a_count_src(a_count_src), .a_pulse_out(a_pulse_out), .b_wave_out(b_wave_out));

`default_nettype wire
